/* hw/sadc_host.sv */
// host controller for a clockless two-pass sampling converter
// assumes device pins are asynchronous; all user ports on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module sadc_host
	import sadc_pkg::*;
#(
	parameter int unsigned DATA_WIDTH = DATA_W
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic continuous_i,
	input wire logic calib_i,
	input wire logic comp_sel_i,
	input wire logic eoc_busy_i,
	input wire logic sample_hold_i,
	input wire logic [DATA_WIDTH-1:0] data_i,
	output logic trigger_o,
	output logic out_enable_o,
	output logic code_complement_select_o,
	output logic busy_o,
	output logic result_valid_o,
	output var sadc_result_type result_o,
	output logic sampling_o
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TRIG = 3'b001,
		ST_WAIT_BUSY = 3'b010,
		ST_CONV = 3'b011,
		ST_SETTLE = 3'b100
	} sadc_state_type;

	localparam logic [CNT_W-1:0] TRIG_CNT = CNT_W'(TRIG_WIDTH_CYC);
	localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(DATA_VALID_CYC + ENA_VALID_CYC);
	localparam logic [CNT_W-1:0] BUSY_TO_CNT = CNT_W'(BUSY_RISE_CYC + SYNC_MARGIN_CYC);
	localparam logic [CNT_W-1:0] CONV_TO_CNT = CNT_W'(CONV_MAX_CYC + 2 * SYNC_MARGIN_CYC);

	sadc_state_type state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] period_reg;
	logic timeout_reg;
	logic [DATA_WIDTH+1:0] pins_sync;
	logic eoc_s;
	logic sh_s;
	logic [DATA_WIDTH-1:0] data_s;
	logic period_done;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	sadc_sync #(
		.WIDTH(DATA_WIDTH + 2)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.async_i({eoc_busy_i, sample_hold_i, data_i}),
		.sync_o(pins_sync)
	);
	assign eoc_s = pins_sync[DATA_WIDTH+1];
	assign sh_s = pins_sync[DATA_WIDTH];
	assign data_s = pins_sync[DATA_WIDTH-1:0];

	// sampling status mirrors the synced indicator
	assign sampling_o = sh_s;
	assign busy_o = (state_reg != ST_IDLE);
	assign code_complement_select_o = comp_sel_i;

	// ------------------------------------------------------------
	// trigger period timer
	// ------------------------------------------------------------
	// next trigger no sooner than the chosen rate
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			period_reg <= '0;
		end else if (state_reg == ST_IDLE && period_done && (start_i || continuous_i) && !eoc_s) begin
			period_reg <= calib_i ? CNT_W'(PERIOD_CAL_CYC - 1) : CNT_W'(PERIOD_FAST_CYC - 1);
		end else if (period_reg != '0) begin
			period_reg <= period_reg - 1'b1;
		end
	end
	assign period_done = (period_reg == '0);

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			trigger_o <= 1'b0;
			out_enable_o <= 1'b0;
			timeout_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					out_enable_o <= 1'b0;
					// only start while idle, one trigger per conversion
					if (period_done && (start_i || continuous_i) && !eoc_s) begin
						state_reg <= ST_TRIG;
						trigger_o <= 1'b1;
						cnt_reg <= TRIG_CNT - 1'b1;
						timeout_reg <= 1'b0;
					end
				end
				ST_TRIG: begin
					// hold the trigger high for its least width
					if (cnt_reg == '0) begin
						trigger_o <= 1'b0;
						state_reg <= ST_WAIT_BUSY;
						cnt_reg <= BUSY_TO_CNT;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				ST_WAIT_BUSY: begin
					// busy expected shortly after trigger fall
					if (eoc_s) begin
						state_reg <= ST_CONV;
						cnt_reg <= CONV_TO_CNT;
					end else if (cnt_reg == '0) begin
						timeout_reg <= 1'b1;
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				ST_CONV: begin
					// busy fall marks the merged result ready
					if (!eoc_s) begin
						state_reg <= ST_SETTLE;
						out_enable_o <= 1'b1;
						cnt_reg <= SETTLE_CNT;
					end else if (cnt_reg == '0) begin
						timeout_reg <= 1'b1;
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				ST_SETTLE: begin
					// wait out data-valid and enable delays before latch
					if (cnt_reg == '0) begin
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// result capture
	// ------------------------------------------------------------
	// latch inside the valid window, well before 1300 ns
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			result_o <= '0;
			result_valid_o <= 1'b0;
		end else begin
			result_valid_o <= 1'b0;
			if (state_reg == ST_SETTLE && cnt_reg == '0) begin
				result_o.code <= data_s;
				result_o.timeout <= 1'b0;
				result_valid_o <= 1'b1;
			end else if (timeout_reg && state_reg == ST_IDLE && !result_o.timeout) begin
				result_o.timeout <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	// helper: cycles the trigger has stood high so far
	logic [CNT_W-1:0] trig_len_reg;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			trig_len_reg <= '0;
		end else if (trigger_o) begin
			trig_len_reg <= trig_len_reg + 1'b1;
		end else begin
			trig_len_reg <= '0;
		end
	end

	property p_trig_width;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$fell(trigger_o) |-> (trig_len_reg == TRIG_CNT);
	endproperty
	a_trig_width: assert property (p_trig_width) else $error("trigger pulse too short");

	property p_no_retrig;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		(state_reg == ST_CONV) |-> !trigger_o;
	endproperty
	a_no_retrig: assert property (p_no_retrig) else $error("trigger during conversion");

	property p_latch_late;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		(state_reg == ST_CONV && !eoc_s) |-> !result_valid_o [*5];
	endproperty
	a_latch_late: assert property (p_latch_late) else $error("result latched too early");

	property p_oe_before_latch;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(result_valid_o) |-> $past(out_enable_o);
	endproperty
	a_oe_before_latch: assert property (p_oe_before_latch) else $error("latch with buffers off");

	property p_oe_settle;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(out_enable_o) |-> ##[6:8] result_valid_o;
	endproperty
	a_oe_settle: assert property (p_oe_settle) else $error("enable to latch spacing wrong");

	property p_trig_fall_wait;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$fell(trigger_o) |-> (state_reg == ST_WAIT_BUSY);
	endproperty
	a_trig_fall_wait: assert property (p_trig_fall_wait) else $error("no busy wait after trigger");

	property p_sel_pass;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		code_complement_select_o == comp_sel_i;
	endproperty
	a_sel_pass: assert property (p_sel_pass) else $error("code select not driven");

	property p_period;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(trigger_o) |-> ##1 (period_reg != '0);
	endproperty
	a_period: assert property (p_period) else $error("trigger period not enforced");

	c_trig: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) $rose(trigger_o));
	c_result: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) result_valid_o);
	c_timeout: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) timeout_reg);
endmodule : sadc_host
`default_nettype wire

/* hw/sadc_sync.sv */
// three-stage synchroniser with agreement filter for device pins
// assumes inputs are asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module sadc_sync
	import sadc_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] sync_next;

	// ------------------------------------------------------------
	// stages
	// ------------------------------------------------------------
	// first stage feeds only the second
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= async_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// output follows only when second and third agree
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			assign sync_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : sync_o[gi];
		end
	endgenerate

	// filtered output register, one process for the whole word
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_o <= '0;
		end else begin
			sync_o <= sync_next;
		end
	end
endmodule : sadc_sync
`default_nettype wire

/* inc/sadc_pkg.sv */
// conversion-handshake host package: timing constants and carrier types
// assumes a 200 MHz system clock
package sadc_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	// trigger high time, least
	localparam int unsigned TRIG_WIDTH_NS = 200;
	localparam int unsigned TRIG_WIDTH_CYC = (TRIG_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// full-rate trigger period (500 KHz) and calibration period (250 KHz)
	localparam int unsigned RATE_FAST_KHZ = 500;
	localparam int unsigned RATE_CAL_KHZ = 250;
	localparam int unsigned PERIOD_FAST_CYC = (1000000000 / RATE_FAST_KHZ) / CLK_PERIOD_PS;
	localparam int unsigned PERIOD_CAL_CYC = (1000000000 / RATE_CAL_KHZ) / CLK_PERIOD_PS;
	// data valid window after the end-of-conversion fall, 20 ns .. 1300 ns
	localparam int unsigned DATA_VALID_NS = 20;
	localparam int unsigned DATA_VALID_CYC = (DATA_VALID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DATA_HOLD_NS = 1300;
	localparam int unsigned DATA_HOLD_CYC = (DATA_HOLD_NS * 1000) / CLK_PERIOD_PS;
	// enable to data valid, at most
	localparam int unsigned ENA_VALID_NS = 10;
	localparam int unsigned ENA_VALID_CYC = (ENA_VALID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// busy must rise 35 ns after trigger fall; host waits this plus sync margin
	localparam int unsigned BUSY_RISE_NS = 35;
	localparam int unsigned BUSY_RISE_CYC = (BUSY_RISE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// conversion time bound, with margin for timeout
	localparam int unsigned CONV_MAX_NS = 1150;
	localparam int unsigned CONV_MAX_CYC = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned SYNC_MARGIN_CYC = 4;
	localparam int unsigned CNT_W = 12;
	localparam int unsigned DATA_W = 12;

	// pins seen from the device outputs
	typedef struct packed {
		logic eoc_busy;
		logic sample_hold;
		logic [DATA_W-1:0] data;
	} sadc_pins_in_type;

	// captured result handed to the user
	typedef struct packed {
		logic timeout;
		logic [DATA_W-1:0] code;
	} sadc_result_type;
endpackage : sadc_pkg

/* test/sadc_dev_model.sv */
// behavioural converter seen from its pins: trigger in, status and data out
// assumes the host pulses the trigger and reads only after end-of-conversion falls
`timescale 1ns/1ps
`default_nettype none
module sadc_dev_model (
	input wire logic trig_i,
	input wire logic oe_i,
	input wire logic comp_sel_i,
	input wire logic slow_i,
	input wire logic mute_i,
	input wire logic [11:0] code_i,
	output logic eoc_o,
	output logic sh_o,
	output logic [11:0] data_o
);
	logic [11:0] res_reg;
	logic [11:0] word;
	// power-up in sample mode, not busy
	initial begin
		eoc_o = 1'b0;
		sh_o = 1'b1;
		res_reg = 12'h000;
		word = 12'h000;
	end
	// one conversion; triggers during it are not watched
	always begin
		@(posedge trig_i);
		if (!mute_i) begin
			#8 sh_o = 1'b0;
			word = code_i; // both passes merged into one word
			@(negedge trig_i);
			#30 eoc_o = 1'b1;
			#(slow_i ? 1120 : 570) sh_o = 1'b1;
			#30 eoc_o = 1'b0;
			#20 res_reg = comp_sel_i ? word : ~word;
		end
	end
	// disabled outputs show the inverse, never a stale value
	assign #8 data_o = oe_i ? res_reg : ~res_reg;
endmodule : sadc_dev_model
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the converter host controller
// assumes the device model above and the package timing constants
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sadc_pkg::*;
	logic clk_sys_i = 0, nrst_i = 0, start_i = 0, continuous_i = 0, calib_i = 0, comp_sel_i = 1;
	logic slow = 0, mute = 0, prev_trig = 0, ccs, trig, oe, busy, valid, sampling, eoc, sh;
	logic [11:0] code = 12'h000;
	logic [11:0] data;
	logic [16:0] lfsr_reg = 17'h1_61da;
	sadc_result_type result;
	int fails = 0, tests_run = 0, cycles = 0, nvalid = 0, nrise = 0, since = 0, gap = 0, width = 0, tgt = 0, n;
	always #2.5 clk_sys_i = ~clk_sys_i;
	sadc_host DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .start_i(start_i), .continuous_i(continuous_i),
		.calib_i(calib_i), .comp_sel_i(comp_sel_i), .eoc_busy_i(eoc), .sample_hold_i(sh), .data_i(data),
		.trigger_o(trig), .out_enable_o(oe), .code_complement_select_o(ccs), .busy_o(busy),
		.result_valid_o(valid), .result_o(result), .sampling_o(sampling));
	sadc_dev_model dev (.trig_i(trig), .oe_i(oe), .comp_sel_i(ccs), .slow_i(slow), .mute_i(mute),
		.code_i(code), .eoc_o(eoc), .sh_o(sh), .data_o(data));
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [16:0] lfsr(logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr
	function automatic logic [11:0] exp_code(logic [11:0] c, logic cs);
		return cs ? c : ~c;
	endfunction : exp_code
	task automatic close_out();
		$display("counts: %0d checks, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// bounded wait: 0 busy, 1 result pulse, 2 trigger rise count
	task automatic wait_on(input int sel, input logic lvl);
		for (n = 0; n < 3000; n++) begin
			@(negedge clk_sys_i);
			if ((sel == 0 ? busy : sel == 1 ? valid : logic'(nrise >= tgt)) === lvl) return;
		end
		fails++;
		$display("CHECK FAILED wait %0d expected %b seen none", sel, lvl);
	endtask : wait_on
	task automatic run_conv(input logic [11:0] c, input logic cs, input logic sl);
		@(posedge clk_sys_i);
		code <= c;
		comp_sel_i <= cs;
		slow <= sl;
		start_i <= 1'b1;
		wait_on(0, 1'b1);
		check("select pin", ccs, cs);
		@(posedge clk_sys_i);
		start_i <= 1'b0;
		wait_on(1, 1'b1);
		check("code", result.code, exp_code(c, cs));
		check("timeout", result.timeout, 1'b0);
		check("enable at latch", oe, 1'b1);
		check("trigger width", width, TRIG_WIDTH_CYC);
		wait_on(0, 1'b0);
	endtask : run_conv
	// trigger timing monitor, pulse count and hang limit
	always @(negedge clk_sys_i) begin
		cycles++;
		since++;
		if (trig && !prev_trig) begin
			gap = since;
			since = 0;
			nrise++;
			width = 0;
		end
		if (trig) width++;
		if (valid) nvalid++;
		prev_trig = trig;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		int v0;
		repeat (20) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		repeat (6) @(negedge clk_sys_i);
		check("sampling after reset", sampling, 1'b1);
		check("idle trigger", trig, 1'b0);
		check("idle enable", oe, 1'b0);
		check("idle busy", busy, 1'b0);
		$display("test reset done");
		run_conv(12'h800, 1'b1, 1'b0);
		run_conv(12'h800, 1'b0, 1'b0);
		run_conv(12'h001, 1'b1, 1'b1);
		run_conv(12'h001, 1'b0, 1'b1);
		run_conv(12'hfff, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			lfsr_reg = lfsr(lfsr_reg);
			run_conv(lfsr_reg[11:0], lfsr_reg[12], lfsr_reg[13]);
		end
		$display("test single conversions done");
		for (int r = 0; r < 2; r++) begin
			@(posedge clk_sys_i);
			calib_i <= r[0];
			continuous_i <= 1'b1;
			tgt = nrise + 3;
			wait_on(2, 1'b1);
			check("trigger period", gap, r[0] ? PERIOD_CAL_CYC : PERIOD_FAST_CYC);
			@(posedge clk_sys_i);
			continuous_i <= 1'b0;
			wait_on(0, 1'b0);
		end
		$display("test continuous done");
		@(posedge clk_sys_i);
		mute <= 1'b1;
		start_i <= 1'b1;
		v0 = nvalid;
		wait_on(0, 1'b1);
		@(posedge clk_sys_i);
		start_i <= 1'b0;
		wait_on(0, 1'b0);
		@(negedge clk_sys_i);
		check("timeout flag", result.timeout, 1'b1);
		check("no result pulse", nvalid, v0);
		mute <= 1'b0;
		run_conv(12'h5a3, 1'b1, 1'b0);
		$display("test silent device done");
		close_out();
	end
endmodule : testbench
`default_nettype wire
